// ===== common/sync_out_pkg.sv
// Purpose: shared constants for the sync and pixel output stage
// Assumes: registers sit on a 32-bit AXI4-Lite slave, one word each
// Notes:   register byte address is four times its index
package sync_out_pkg;
    // ==========================================================
    // bus shape
    localparam int          DATA_W     = 32;
    localparam int          ADDR_W     = 8;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // ==========================================================
    // register indices
    localparam logic [5:0]  SYNC_CTRL_IDX  = 6'h0E;
    localparam logic [5:0]  LINE_WIDTH_IDX = 6'h10;
    localparam logic [5:0]  PHASE_IDX      = 6'h11;
    localparam logic [5:0]  SLICER_IDX     = 6'h12;
    localparam logic [5:0]  STATUS_IDX     = 6'h13;
    // ==========================================================
    // sync control fields
    localparam int          EDGE_SEL_BIT   = 6;
    localparam int          LINE_POL_BIT   = 5;
    localparam int          FRAME_POL_BIT  = 4;
    localparam int          SLICER_SEL_BIT = 3;
    localparam logic [7:0]  SYNC_CTRL_MASK = 8'h78;
    localparam logic [7:0]  SYNC_CTRL_RST  = 8'h40;
    // ==========================================================
    // widths and reset values
    localparam int          COLOR_W        = 8;
    localparam int          WIDTH_W        = 8;
    localparam int          PHASE_W        = 4;
    localparam int          THR_W          = 6;
    localparam logic [7:0]  LINE_WIDTH_RST = 8'h20;
    localparam logic [3:0]  PHASE_RST      = 4'h0;
    // ==========================================================
    // slicer threshold, held as a count of steps above the negative peak
    localparam int          THR_STEP_MV    = 10;
    localparam int          THR_MIN_MV     = 10;
    localparam int          THR_MAX_MV     = 330;
    localparam int          THR_RST_MV     = 150;
    localparam logic [5:0]  THR_MIN_CODE   = 6'(THR_MIN_MV / THR_STEP_MV);
    localparam logic [5:0]  THR_MAX_CODE   = 6'(THR_MAX_MV / THR_STEP_MV);
    localparam logic [5:0]  THR_RST_CODE   = 6'(THR_RST_MV / THR_STEP_MV);
    // ==========================================================
    // status fields
    localparam int          ST_HSYNC_BIT   = 0;
    localparam int          ST_VSYNC_BIT   = 1;
    localparam int          ST_CMP_BIT     = 2;
    localparam int          ST_BUSY_BIT    = 3;
endpackage

// ===== hdl/tap_delay_line.sv
// Purpose: shift register with a selectable tap
// Assumes: i_tap below DEPTH
// Notes:   tap 0 passes the input straight through, so the caller registers it
module tap_delay_line #(
    parameter int W     = 8,
    parameter int DEPTH = 16,
    parameter int TAP_W = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic [W-1:0]     i_din,
    input  wire logic [TAP_W-1:0] i_tap,
    output      logic [W-1:0]     o_dout
);
    logic [W-1:0] stage_q [1:DEPTH-1];
    logic [W-1:0] tap_w   [DEPTH];

    assign tap_w[0] = i_din;
    assign o_dout   = tap_w[i_tap];

    genvar g;
    generate
        for (g = 1; g < DEPTH; g++) begin : g_stage
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    stage_q[g] <= '0;
                end else begin
                    stage_q[g] <= tap_w[g-1];
                end
            end
            assign tap_w[g] = stage_q[g];
        end
    endgenerate
endmodule

// ===== hdl/sync_pixel_output.sv
// Purpose: sync processing and pixel output stage of a graphics digitizer
// Assumes: i_pix_clk runs at twice the pixel rate; one pixel period is two edges
// Notes:   settings cross to the pixel domain by a toggle handshake
module sync_pixel_output
    #(
    parameter int COLOR_W = sync_out_pkg::COLOR_W,
    parameter int PHASE_W = sync_out_pkg::PHASE_W
) (
    input  wire logic                             i_clk,
    input  wire logic                             i_resetn,
    input  wire logic                             i_awvalid,
    output      logic                             o_awready,
    input  wire logic [sync_out_pkg::ADDR_W-1:0]  i_awaddr,
    input  wire logic                             i_wvalid,
    output      logic                             o_wready,
    input  wire logic [sync_out_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic [3:0]                       i_wstrb,
    output      logic                             o_bvalid,
    input  wire logic                             i_bready,
    output      logic [1:0]                       o_bresp,
    input  wire logic                             i_arvalid,
    output      logic                             o_arready,
    input  wire logic [sync_out_pkg::ADDR_W-1:0]  i_araddr,
    output      logic                             o_rvalid,
    input  wire logic                             i_rready,
    output      logic [sync_out_pkg::DATA_W-1:0]  o_rdata,
    output      logic [1:0]                       o_rresp,
    output      logic [sync_out_pkg::THR_W-1:0]   o_slicer_threshold,
    input  wire logic                             i_pix_clk,
    input  wire logic                             i_line_sync_in,
    input  wire logic                             i_frame_sync_in,
    input  wire logic                             i_green_sync_cmp,
    input  wire logic [COLOR_W-1:0]               i_red,
    input  wire logic [COLOR_W-1:0]               i_green,
    input  wire logic [COLOR_W-1:0]               i_blue,
    output      logic [COLOR_W-1:0]               o_red,
    output      logic [COLOR_W-1:0]               o_green,
    output      logic [COLOR_W-1:0]               o_blue,
    output      logic                             o_pixel_strobe_out,
    output      logic                             o_line_sync_out,
    output      logic                             o_frame_sync_out,
    output      logic                             o_green_sync_slicer_out
);
    import sync_out_pkg::*;

    localparam int CFG_W  = 4 + WIDTH_W + PHASE_W;
    localparam int PACK_W = 3 + 3 * COLOR_W;
    localparam int DEPTH  = 2 ** PHASE_W;

    // ==========================================================
    // register bus, write side
    logic               awready_q, wready_q, bvalid_q, aw_held_q, w_held_q;
    logic [1:0]         bresp_q;
    logic [5:0]         wr_idx_q;
    logic [7:0]         wr_byte_q;
    logic               wr_en_q;
    logic [7:0]         ctrl_q;
    logic [WIDTH_W-1:0] width_q;
    logic [PHASE_W-1:0] phase_q;
    logic [THR_W-1:0]   thr_q;

    wire aw_hs     = i_awvalid & awready_q;
    wire w_hs      = i_wvalid & wready_q;
    wire wr_go     = aw_held_q & w_held_q;
    wire aw_held_d = wr_go ? 1'b0 : (aw_held_q | aw_hs);
    wire w_held_d  = wr_go ? 1'b0 : (w_held_q | w_hs);
    wire bvalid_d  = wr_go ? 1'b1 : (bvalid_q & ~i_bready);
    wire wr_known  = (wr_idx_q == SYNC_CTRL_IDX) | (wr_idx_q == LINE_WIDTH_IDX)
                   | (wr_idx_q == PHASE_IDX) | (wr_idx_q == SLICER_IDX)
                   | (wr_idx_q == STATUS_IDX);
    wire wr_lane   = wr_go & wr_en_q;
    wire [THR_W-1:0] thr_in  = wr_byte_q[THR_W-1:0];
    wire [THR_W-1:0] thr_lim = (thr_in < THR_MIN_CODE) ? THR_MIN_CODE
                             : (thr_in > THR_MAX_CODE) ? THR_MAX_CODE : thr_in;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            bvalid_q  <= bvalid_d;
            awready_q <= ~aw_held_d & ~bvalid_d;
            wready_q  <= ~w_held_d & ~bvalid_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_idx_q  <= 6'h0;
            wr_byte_q <= 8'h00;
            wr_en_q   <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_hs) begin
                wr_idx_q <= i_awaddr[7:2];
            end
            if (w_hs) begin
                wr_byte_q <= i_wdata[7:0];
                wr_en_q   <= i_wstrb[0];
            end
            if (wr_go) begin
                bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q  <= SYNC_CTRL_RST;
            width_q <= LINE_WIDTH_RST;
            phase_q <= PHASE_RST;
            thr_q   <= THR_RST_CODE;
        end else if (wr_lane) begin
            if (wr_idx_q == SYNC_CTRL_IDX) ctrl_q <= wr_byte_q & SYNC_CTRL_MASK;
            if (wr_idx_q == LINE_WIDTH_IDX) width_q <= wr_byte_q[WIDTH_W-1:0];
            if (wr_idx_q == PHASE_IDX) phase_q <= wr_byte_q[PHASE_W-1:0];
            if (wr_idx_q == SLICER_IDX) thr_q <= thr_lim;
        end
    end

    // ==========================================================
    // register bus, read side
    logic              arready_q, rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0]        rresp_q;
    logic [3:0]        status_s1, status_s2;
    logic              cfg_busy;

    wire        ar_hs    = i_arvalid & arready_q;
    wire        rvalid_d = ar_hs ? 1'b1 : (rvalid_q & ~i_rready);
    wire [5:0]  rd_idx   = i_araddr[7:2];
    wire        rd_ctrl  = rd_idx == SYNC_CTRL_IDX;
    wire        rd_width = rd_idx == LINE_WIDTH_IDX;
    wire        rd_phase = rd_idx == PHASE_IDX;
    wire        rd_thr   = rd_idx == SLICER_IDX;
    wire        rd_stat  = rd_idx == STATUS_IDX;
    wire        rd_known = rd_ctrl | rd_width | rd_phase | rd_thr | rd_stat;
    wire [DATA_W-1:0] rd_word =
          rd_ctrl  ? DATA_W'(ctrl_q)
        : rd_width ? DATA_W'(width_q)
        : rd_phase ? DATA_W'(phase_q)
        : rd_thr   ? DATA_W'(thr_q)
        : rd_stat  ? DATA_W'({cfg_busy, status_s2[2:0]})
        : 32'h0000_0000;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else begin
            rvalid_q  <= rvalid_d;
            arready_q <= ~rvalid_d;
            if (ar_hs) begin
                rdata_q <= rd_word;
                rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // settings crossing; the sent word is frozen while a request is open
    logic [CFG_W-1:0] sent_q, cfg_pix_q;
    logic             req_q, ack_s1, ack_s2;
    logic             req_s1, req_s2, req_seen_q;
    logic             hs_s1, hs_s2, hs_prev_q, hs_dly_q;
    logic             vs_s1, vs_s2, cmp_s1, cmp_s2;
    wire  [CFG_W-1:0] cfg_live = {ctrl_q[6:3], width_q, phase_q};
    localparam logic [CFG_W-1:0] CFG_RST = {SYNC_CTRL_RST[6:3], LINE_WIDTH_RST, PHASE_RST};

    assign cfg_busy = req_q ^ ack_s2;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sent_q    <= CFG_RST;
            req_q     <= 1'b0;
            ack_s1    <= 1'b0;
            ack_s2    <= 1'b0;
            status_s1 <= 4'h0;
            status_s2 <= 4'h0;
        end else begin
            ack_s1    <= req_seen_q;
            ack_s2    <= ack_s1;
            status_s1 <= {1'b0, cmp_s2, vs_s2, hs_s2};
            status_s2 <= status_s1;
            if (!cfg_busy && cfg_live != sent_q) begin
                sent_q <= cfg_live;
                req_q  <= ~req_q;
            end
        end
    end

    // ==========================================================
    // pixel domain: reset release, pin synchronisers, settings capture
    logic pix_rstn_s1, pix_rstn_q;

    always_ff @(posedge i_pix_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pix_rstn_s1 <= 1'b0;
            pix_rstn_q  <= 1'b0;
        end else begin
            pix_rstn_s1 <= 1'b1;
            pix_rstn_q  <= pix_rstn_s1;
        end
    end

    always_ff @(posedge i_pix_clk or negedge pix_rstn_q) begin
        if (!pix_rstn_q) begin
            {hs_s1, hs_s2, hs_prev_q, hs_dly_q} <= 4'h0;
            {vs_s1, vs_s2, cmp_s1, cmp_s2}      <= 4'h0;
            {req_s1, req_s2, req_seen_q}        <= 3'h0;
            cfg_pix_q <= CFG_RST;
        end else begin
            hs_s1     <= i_line_sync_in;
            hs_s2     <= hs_s1;
            hs_prev_q <= hs_s2;
            hs_dly_q  <= hs_s2;
            vs_s1     <= i_frame_sync_in;
            vs_s2     <= vs_s1;
            cmp_s1    <= i_green_sync_cmp;
            cmp_s2    <= cmp_s1;
            req_s1    <= req_q;
            req_s2    <= req_s1;
            if (req_s2 != req_seen_q) begin
                cfg_pix_q  <= sent_q;
                req_seen_q <= req_s2;
            end
        end
    end

    wire               edge_sel   = cfg_pix_q[CFG_W-1];
    wire               line_pol   = cfg_pix_q[CFG_W-2];
    wire               frame_pol  = cfg_pix_q[CFG_W-3];
    wire               slicer_sel = cfg_pix_q[CFG_W-4];
    wire [WIDTH_W-1:0] cfg_width  = cfg_pix_q[PHASE_W +: WIDTH_W];
    wire [PHASE_W-1:0] cfg_phase  = cfg_pix_q[PHASE_W-1:0];

    // ==========================================================
    // line sync rebuild; line sync is also the pll reference, outside this logic
    logic               strobe_q, line_pend_q, line_st_q, frame_st_q;
    logic [WIDTH_W-1:0] line_cnt_q;
    logic [COLOR_W-1:0] red_st_q, green_st_q, blue_st_q;

    wire load     = ~strobe_q;
    wire hs_rise  = hs_s2 & ~hs_prev_q;
    wire hs_fall  = ~hs_s2 & hs_prev_q;
    wire lead     = edge_sel ? hs_rise : hs_fall;
    wire pend_d   = lead | (line_pend_q & ~load);
    wire [WIDTH_W-1:0] cnt_dec = (line_cnt_q != '0) ? line_cnt_q - 1'b1 : line_cnt_q;
    wire [WIDTH_W-1:0] cnt_d   = !load ? line_cnt_q
                               : line_pend_q ? cfg_width : cnt_dec;

    always_ff @(posedge i_pix_clk or negedge pix_rstn_q) begin
        if (!pix_rstn_q) begin
            strobe_q    <= 1'b0;
            line_pend_q <= 1'b0;
            line_cnt_q  <= '0;
            line_st_q   <= 1'b0;
            frame_st_q  <= 1'b0;
            red_st_q    <= '0;
            green_st_q  <= '0;
            blue_st_q   <= '0;
        end else begin
            strobe_q    <= ~strobe_q;
            line_pend_q <= pend_d;
            line_cnt_q  <= cnt_d;
            if (load) begin
                line_st_q  <= (cnt_d != '0) ^ line_pol;
                frame_st_q <= vs_s2 ^ frame_pol;
                red_st_q   <= i_red;
                green_st_q <= i_green;
                blue_st_q  <= i_blue;
            end
        end
    end

    // ==========================================================
    // phase shift: one delay line for strobe, line and frame syncs and colour; the slicer output bypasses it
    wire [PACK_W-1:0] pack_in = {strobe_q, line_st_q, frame_st_q,
                                 red_st_q, green_st_q, blue_st_q};
    wire [PACK_W-1:0] pack_out;

    tap_delay_line #(
        .W     (PACK_W),
        .DEPTH (DEPTH),
        .TAP_W (PHASE_W)
    ) u_phase (
        .i_clk    (i_pix_clk),
        .i_resetn (pix_rstn_q),
        .i_din    (pack_in),
        .i_tap    (cfg_phase),
        .o_dout   (pack_out)
    );

    logic [PACK_W-1:0] out_q;
    logic              slicer_q;

    always_ff @(posedge i_pix_clk or negedge pix_rstn_q) begin
        if (!pix_rstn_q) begin
            out_q    <= '0;
            slicer_q <= 1'b0;
        end else begin
            out_q    <= pack_out;
            slicer_q <= slicer_sel ? hs_dly_q : cmp_s2;
        end
    end

    assign {o_pixel_strobe_out, o_line_sync_out, o_frame_sync_out,
            o_red, o_green, o_blue} = out_q;
    assign o_green_sync_slicer_out = slicer_q;
    assign o_slicer_threshold      = thr_q;
    assign o_awready = awready_q;
    assign o_wready  = wready_q;
    assign o_bvalid  = bvalid_q;
    assign o_bresp   = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid  = rvalid_q;
    assign o_rdata   = rdata_q;
    assign o_rresp   = rresp_q;

    // ==========================================================
    // checks
    sequence s_line_start;
        load && line_pend_q && cfg_width != '0;
    endsequence
    property p_line_start;
        @(posedge i_pix_clk) disable iff (!pix_rstn_q)
        s_line_start |=> line_cnt_q == $past(cfg_width) && !load ##1 load;
    endproperty
    a_line_start: assert property (p_line_start)
        else $error("line pulse did not load programmed width");

    property p_line_level;
        @(posedge i_pix_clk) disable iff (!pix_rstn_q)
        load |=> line_st_q == (($past(cnt_d) != '0) ^ $past(line_pol));
    endproperty
    a_line_level: assert property (p_line_level)
        else $error("line sync stage level wrong");

    property p_trailing_ignored;
        @(posedge i_pix_clk) disable iff (!pix_rstn_q)
        (edge_sel ? hs_fall : hs_rise) && !line_pend_q && !load |=> !line_pend_q;
    endproperty
    a_trailing_ignored: assert property (p_trailing_ignored)
        else $error("trailing line sync edge was acted on");

    property p_leading_taken;
        @(posedge i_pix_clk) disable iff (!pix_rstn_q)
        lead |=> line_pend_q ##1 line_cnt_q == $past(cfg_width) || !$past(load);
    endproperty
    a_leading_taken: assert property (p_leading_taken)
        else $error("leading line sync edge missed");

    property p_frame_follow;
        @(posedge i_pix_clk) disable iff (!pix_rstn_q)
        load |=> frame_st_q == ($past(vs_s2) ^ $past(frame_pol));
    endproperty
    a_frame_follow: assert property (p_frame_follow)
        else $error("frame sync stage does not follow input");

    property p_phase_zero;
        @(posedge i_pix_clk) disable iff (!pix_rstn_q)
        cfg_phase == '0 |=> out_q == $past(pack_in);
    endproperty
    a_phase_zero: assert property (p_phase_zero)
        else $error("outputs not aligned at zero phase");

    property p_strobe_toggle;
        @(posedge i_pix_clk) disable iff (!pix_rstn_q)
        strobe_q |=> !strobe_q ##1 strobe_q;
    endproperty
    a_strobe_toggle: assert property (p_strobe_toggle)
        else $error("pixel strobe stopped toggling");

    property p_slicer_path;
        @(posedge i_pix_clk) disable iff (!pix_rstn_q)
        1'b1 |=> slicer_q == ($past(slicer_sel) ? $past(hs_dly_q) : $past(cmp_s2));
    endproperty
    a_slicer_path: assert property (p_slicer_path)
        else $error("slicer output source wrong");

    property p_thr_range;
        @(posedge i_clk) disable iff (!i_resetn)
        thr_q >= THR_MIN_CODE && thr_q <= THR_MAX_CODE;
    endproperty
    a_thr_range: assert property (p_thr_range)
        else $error("slicer threshold out of range");

    property p_write_answer;
        @(posedge i_clk) disable iff (!i_resetn)
        aw_hs && w_hs |=> ##1 bvalid_q;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response late");
endmodule

// ===== sim/scaler_capture_model.sv
// Purpose: downstream capture model for the pixel and sync outputs
// Assumes: line pulse is high while its polarity bit is clear
// Notes:   samples on the falling strobe edge, away from the launch edge
module scaler_capture_model (
    input  wire logic       i_strobe,
    input  wire logic       i_line,
    input  wire logic [7:0] i_red,
    output      logic [7:0] o_red_cap,
    output      int         o_width,
    output      int         o_pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    int         run      = 0;
    int         width_q  = 0;
    int         pulses_q = 0;
    logic [7:0] red_q    = '0;
    assign o_red_cap = red_q;
    assign o_width   = width_q;
    assign o_pulses  = pulses_q;
    // width counted in strobe periods, one per pixel
    always @(negedge i_strobe) begin
        red_q <= i_red;
        if (i_line) begin
            run <= run + 1;
        end else if (run != 0) begin
            width_q  <= run;
            pulses_q <= pulses_q + 1;
            run      <= 0;
        end
    end
endmodule

// ===== sim/testbench.sv
// Purpose: register and pixel path checks of the sync output stage
// Assumes: settings land in the pixel domain within 16 pixel-clock edges
// Notes:   pixel pins change only on pixel-clock edges
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_resetn = 0, i_pix_clk = 0;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    logic [7:0] i_awaddr = '0, i_araddr = '0, i_red = '0, i_green = '0, i_blue = '0;
    logic [31:0] i_wdata = '0;
    logic [3:0] i_wstrb = 4'hF;
    logic i_line_sync_in = 0, i_frame_sync_in = 0, i_green_sync_cmp = 0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_pixel_strobe_out;
    logic o_line_sync_out, o_frame_sync_out, o_green_sync_slicer_out;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [5:0] o_slicer_threshold;
    logic [7:0] o_red, o_green, o_blue, red_cap;
    int width, pulses, p0, error_cnt = 0, tests_run = 0, cycles = 0;
    sync_pixel_output dut (.i_clk, .i_resetn, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
        .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
        .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_slicer_threshold, .i_pix_clk,
        .i_line_sync_in, .i_frame_sync_in, .i_green_sync_cmp, .i_red, .i_green, .i_blue,
        .o_red, .o_green, .o_blue, .o_pixel_strobe_out, .o_line_sync_out, .o_frame_sync_out,
        .o_green_sync_slicer_out);
    scaler_capture_model far_end (.i_strobe(o_pixel_strobe_out), .i_line(o_line_sync_out),
        .i_red(o_red), .o_red_cap(red_cap), .o_width(width), .o_pulses(pulses));
    // ==========================================================
    // clocks and hang guard
    initial forever #5 i_clk = ~i_clk;
    initial begin
        #13;
        forever #40 i_pix_clk = ~i_pix_clk;
    end
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt++;
            finish_test();
        end
    end
    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_bready <= 1;
        do begin
            @(posedge i_clk);
            if (o_awready) i_awvalid <= 0;
            if (o_wready) i_wvalid <= 0;
        end while (o_bvalid !== 1'b1);
        i_bready <= 0;
        chk(o_bresp, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] r);
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1;
        i_rready <= 1;
        do begin
            @(posedge i_clk);
            if (o_arready) i_arvalid <= 0;
        end while (o_rvalid !== 1'b1);
        i_rready <= 0;
        chk(o_rdata, exp);
        chk(o_rresp, r);
    endtask
    task automatic pw(input int n);
        repeat (n) @(posedge i_pix_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge i_clk);
        i_resetn <= 1;
        rd(8'h38, 32'h0000_0040, 2'h0);
        rd(8'h40, 32'h0000_0020, 2'h0);
        rd(8'h48, 32'h0000_000F, 2'h0);
        chk(o_slicer_threshold, 32'h0000_000F);
        rd(8'h00, 32'h0000_0000, sync_out_pkg::RESP_SLVERR);
        wr(8'h48, 32'h0000_0000, 2'h0);
        rd(8'h48, 32'h0000_0001, 2'h0);
        wr(8'h48, 32'h0000_0028, 2'h0);
        rd(8'h48, 32'h0000_0021, 2'h0);
        chk(o_slicer_threshold, 32'h0000_0021);
        wr(8'h40, 32'h0000_0003, 2'h0);
        pw(16);
        i_line_sync_in <= 1;
        pw(8);
        chk(o_line_sync_out, 1);
        pw(4);
        i_line_sync_in <= 0;
        pw(16);
        chk(width, 3);
        chk(pulses, 1);
        wr(8'h38, 32'h0000_0000, 2'h0);
        pw(16);
        p0 = pulses;
        i_line_sync_in <= 1;
        pw(8);
        chk(o_line_sync_out, 0);
        pw(4);
        i_line_sync_in <= 0;
        pw(16);
        chk(pulses, p0 + 1);
        i_frame_sync_in <= 1;
        pw(12);
        chk(o_frame_sync_out, 1);
        wr(8'h38, 32'h0000_0010, 2'h0);
        pw(16);
        chk(o_frame_sync_out, 0);
        i_red <= 8'h81;
        i_green <= 8'h42;
        i_blue <= 8'h18;
        pw(8);
        chk(red_cap, 8'h81);
        chk(o_green, 8'h42);
        chk(o_blue, 8'h18);
        wr(8'h44, 32'h0000_0005, 2'h0);
        pw(16);
        chk(red_cap, 8'h81);
        i_red <= 8'h3C;
        pw(16);
        chk(red_cap, 8'h3C);
        wr(8'h38, 32'h0000_0000, 2'h0);
        pw(1);
        i_green_sync_cmp <= 1;
        pw(12);
        chk(o_green_sync_slicer_out, 1);
        wr(8'h38, 32'h0000_0008, 2'h0);
        pw(16);
        chk(o_green_sync_slicer_out, 0);
        i_line_sync_in <= 1;
        pw(12);
        chk(o_green_sync_slicer_out, 1);
        i_line_sync_in <= 0;
        wr(8'h38, 32'h0000_0020, 2'h0);
        pw(24);
        chk(o_line_sync_out, 1);
        rd(8'h4C, 32'h0000_0006, 2'h0);
        finish_test();
    end
endmodule
